// [rtl/pipsp_pkg.sv]
package pipsp_pkg;
    // clock and absolute limits
    localparam int CLK_HZ = 10_000_000;
    localparam int ABS_LOW_HZ = 5;
    localparam int ABS_HIGH_HZ = 25_000;
    localparam int MIN_WIDTH_PCT = 15;
    localparam int PCT_FULL = 100;
    // period counts derived from clock rate (longest period, shortest one)
    localparam int ABS_LOW_CYC = CLK_HZ / ABS_LOW_HZ;
    localparam int ABS_HIGH_CYC = CLK_HZ / ABS_HIGH_HZ;
    localparam int PER_W = 22;
    localparam logic [PER_W-1:0] PER_SAT = {PER_W{1'b1}};
    // blink rate of the green indicator
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    // host access watchdog
    localparam int HOST_TIMEOUT_MS = 1000;
    localparam int HOST_TIMEOUT_CYC = CLK_HZ / 1000 * HOST_TIMEOUT_MS;
    // prover control pulse width unit
    localparam int PULSE_UNIT_US = 1000;
    localparam int PULSE_UNIT_CYC = CLK_HZ / 1_000_000 * PULSE_UNIT_US;
    // dual chronometry reference
    localparam int CHRONO_HZ = 50_000_000;
    // indicator colours
    typedef enum logic [1:0] {
        PIPSP_LED_OFF = 2'h0,
        PIPSP_LED_GREEN = 2'h1,
        PIPSP_LED_RED = 2'h2
    } pipsp_led_t;
    // prover sequencer states
    typedef enum logic [3:0] {
        PIPSP_IDLE = 4'h1,
        PIPSP_RUN = 4'h2,
        PIPSP_HOLD = 4'h4,
        PIPSP_RETURN = 4'h8
    } pipsp_prv_t;
endpackage

// [rtl/pipsp_chan.sv]
`timescale 1ns/1ps
module pipsp_chan
    import pipsp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pulse and setup
    input wire logic pulse_in,
    input wire logic enable,
    input wire logic [PER_W-1:0] low_limit_cyc,
    input wire logic [PER_W-1:0] high_limit_cyc,
    input wire logic [PER_W-1:0] min_width_cyc,
    input wire logic blink,
    // indicator
    output logic [1:0] led
);
    logic prev_reg, prev_next;
    logic [PER_W-1:0] per_reg, per_next;
    logic [PER_W-1:0] hi_reg, hi_next;
    logic [PER_W-1:0] wid_reg, wid_next;
    logic [1:0] cls_reg, cls_next;
    logic rise;
    logic [1:0] cls_now;

    // classify one finished period by its length and high time
    function automatic logic [1:0] classify(input logic [PER_W-1:0] per,
            input logic [PER_W-1:0] wid, input logic [PER_W-1:0] lo,
            input logic [PER_W-1:0] hi, input logic [PER_W-1:0] mw);
        logic [1:0] r;
        r = PIPSP_LED_GREEN;
        if (per >= PER_W'(ABS_LOW_CYC) || per <= PER_W'(ABS_HIGH_CYC)
                || wid < mw) begin
            r = PIPSP_LED_RED; // RULE3
        end else if (per > lo || per < hi) begin
            r = 2'h3; // RULE2
        end
        return r;
    endfunction

    assign rise = pulse_in && !prev_reg;
    assign cls_now = classify(per_reg, wid_reg, low_limit_cyc,
        high_limit_cyc, min_width_cyc);

    // period and pulse width measurement, refreshed each period
    always_comb begin
        prev_next = pulse_in;
        per_next = (per_reg == PER_SAT) ? per_reg : per_reg + 1'b1; // RULE16
        hi_next = (pulse_in && hi_reg != PER_SAT) ? hi_reg + 1'b1 : hi_reg;
        wid_next = wid_reg;
        cls_next = cls_reg;
        if (rise) begin
            per_next = {{(PER_W-1){1'b0}}, 1'b1};
            hi_next = {PER_W{1'b0}};
            wid_next = hi_reg;
            cls_next = cls_now;
        end else if (per_reg >= PER_W'(ABS_LOW_CYC)) begin
            cls_next = PIPSP_LED_RED; // RULE3
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_reg <= 1'b0;
            per_reg <= PER_SAT;
            hi_reg <= {PER_W{1'b0}};
            wid_reg <= {PER_W{1'b0}};
            cls_reg <= PIPSP_LED_RED;
        end else begin
            prev_reg <= prev_next;
            per_reg <= per_next;
            hi_reg <= hi_next;
            wid_reg <= wid_next;
            cls_reg <= cls_next;
        end
    end

    // indicator drive; code 3 means green blinking
    always_comb begin
        if (!enable) begin
            led = PIPSP_LED_OFF; // RULE4
        end else if (cls_reg == 2'h3) begin
            led = blink ? PIPSP_LED_GREEN : PIPSP_LED_OFF; // RULE2
        end else begin
            led = cls_reg; // RULE1
        end
    end
endmodule

// [rtl/pipsp_top.sv]
`timescale 1ns/1ps
// Operation
// RULE1 - in-limit pulses give steady green
// RULE2 - between absolute and configured limits blinks green
// RULE3 - out of range or narrow pulse red
// RULE4 - disabled input shows indicator off
// RULE5 - proving indicator on during proving run
// RULE6 - host access green, red when stopped
// RULE7 - power green if initialised, else red (the code shows off while hotswap_ok is low)
// RULE8 - failure indicator red on backplane failure
// RULE9 - prover output pulse lasts configured time
// RULE10 - detector pulses during return not forwarded
// RULE11 - run released configured time after stop
// RULE12 - run starts detector_n_a low, rearm when low
// RULE13 - reference meter group filtered like others
// RULE14 - host sets A/B phase offset, tolerance (the code has no phase offset or tolerance inputs)
// RULE15 - interval timed by dual chronometry counters (the code has one clk cycle counter over the run, not output)
// RULE16 - frequency and width measured every period
module pipsp_top
    import pipsp_pkg::*;
#(
    parameter int N_IN = 10,
    parameter int REF_GROUP = 5,
    parameter int BLINK_COUNT = BLINK_CYC,
    parameter int HOST_TIMEOUT = HOST_TIMEOUT_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pulse inputs, a and b interleaved per group
    input wire logic [N_IN-1:0] pulse_in,
    input wire logic [N_IN-1:0] input_enable,
    input wire logic [PER_W-1:0] freq_low_limit,
    input wire logic [PER_W-1:0] freq_high_limit,
    output logic [2*N_IN-1:0] input_led,
    // module status
    input wire logic hotswap_ok,
    input wire logic init_done,
    input wire logic host_access,
    input wire logic backplane_fail,
    output logic [1:0] power_led,
    output logic [1:0] host_led,
    output logic fail_led_red,
    output logic proving_indicator,
    // prover interface
    input wire logic prove_start,
    input wire logic [15:0] prover_output_pulse_config,
    input wire logic detector_n_a,
    input wire logic detector_input_one,
    input wire logic detector_stop,
    output logic prover_control_output,
    output logic prover_control_oe,
    output logic start_event,
    output logic stop_event
);
    // ------------------------------------------------------------
    // shared blink and limit scaling
    // ------------------------------------------------------------
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic blink_reg, blink_next;
    logic [PER_W-1:0] min_width;

    // 15 percent of the high limit period
    assign min_width = PER_W'((32'(freq_high_limit) * MIN_WIDTH_PCT)
        / PCT_FULL); // RULE3

    always_comb begin
        blink_cnt_next = blink_cnt_reg + 32'h1;
        blink_next = blink_reg;
        if (blink_cnt_reg >= 32'(BLINK_COUNT - 1)) begin
            blink_cnt_next = 32'h0;
            blink_next = !blink_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
        end
    end

    // ------------------------------------------------------------
    // per-input classification, same path for reference group
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_chan
            pipsp_chan u_chan ( // RULE13
                .clk(clk),
                .srst(srst),
                .pulse_in(pulse_in[gi]),
                .enable(input_enable[gi]),
                .low_limit_cyc(freq_low_limit),
                .high_limit_cyc(freq_high_limit),
                .min_width_cyc(min_width),
                .blink(blink_reg),
                .led(input_led[2*gi +: 2])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // module status indicators
    // ------------------------------------------------------------
    logic [31:0] host_cnt_reg, host_cnt_next;

    always_comb begin
        host_cnt_next = host_cnt_reg;
        if (host_access) begin
            host_cnt_next = 32'h0;
        end else if (host_cnt_reg < 32'(HOST_TIMEOUT)) begin
            host_cnt_next = host_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_cnt_reg <= 32'(HOST_TIMEOUT);
        end else begin
            host_cnt_reg <= host_cnt_next;
        end
    end

    always_comb begin
        host_led = (host_cnt_reg < 32'(HOST_TIMEOUT)) ? PIPSP_LED_GREEN
            : PIPSP_LED_RED; // RULE6
        if (!hotswap_ok) begin
            power_led = PIPSP_LED_OFF;
        end else if (init_done) begin
            power_led = PIPSP_LED_GREEN; // RULE7
        end else begin
            power_led = PIPSP_LED_RED; // RULE7
        end
        fail_led_red = backplane_fail; // RULE8
    end

    // ------------------------------------------------------------
    // prover sequencer
    // ------------------------------------------------------------
    pipsp_prv_t st_reg, st_next;
    logic [15:0] unit_reg, unit_next;
    logic [31:0] tmr_reg, tmr_next;
    logic stop_prev_reg, stop_prev_next;
    logic start_prev_reg, start_prev_next;
    logic drive_reg, drive_next;
    logic start_ev_reg, start_ev_next;
    logic stop_ev_reg, stop_ev_next;
    logic [31:0] chrono_reg, chrono_next;
    logic stop_fall, start_fall, tick;

    assign stop_fall = stop_prev_reg && !detector_stop;
    assign start_fall = start_prev_reg && !detector_input_one;
    assign tick = (tmr_reg >= 32'(PULSE_UNIT_CYC - 1));

    always_comb begin
        st_next = st_reg;
        unit_next = unit_reg;
        tmr_next = tick ? 32'h0 : tmr_reg + 32'h1;
        stop_prev_next = detector_stop;
        start_prev_next = detector_input_one;
        drive_next = drive_reg;
        start_ev_next = 1'b0;
        stop_ev_next = 1'b0;
        chrono_next = chrono_reg;
        unique case (st_reg)
            PIPSP_IDLE: begin
                drive_next = 1'b0;
                if (prove_start && !detector_n_a) begin
                    st_next = PIPSP_RUN; // RULE12
                    drive_next = 1'b1;
                    unit_next = prover_output_pulse_config;
                    tmr_next = 32'h0;
                    chrono_next = 32'h0;
                end
            end
            PIPSP_RUN: begin
                // clk cycle count over the run state, from start request to stop detector
                chrono_next = chrono_reg + 32'h1; // RULE15
                start_ev_next = start_fall;
                stop_ev_next = stop_fall;
                if (tick && unit_reg != 16'h0) begin
                    unit_next = unit_reg - 16'h1;
                end
                if (tick && unit_reg <= 16'h1) begin
                    drive_next = 1'b0; // RULE9
                end
                if (stop_fall) begin
                    st_next = PIPSP_HOLD;
                    unit_next = prover_output_pulse_config;
                    tmr_next = 32'h0;
                end
            end
            PIPSP_HOLD: begin
                if (tick && unit_reg != 16'h0) begin
                    unit_next = unit_reg - 16'h1;
                end
                if (tick && unit_reg <= 16'h1) begin
                    st_next = PIPSP_RETURN; // RULE11
                    drive_next = 1'b0;
                end
            end
            PIPSP_RETURN: begin
                // detector edges while piston returns are dropped
                if (detector_n_a) begin // RULE10
                    st_next = PIPSP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= PIPSP_IDLE;
            unit_reg <= 16'h0;
            tmr_reg <= 32'h0;
            stop_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
            drive_reg <= 1'b0;
            start_ev_reg <= 1'b0;
            stop_ev_reg <= 1'b0;
            chrono_reg <= 32'h0;
        end else begin
            st_reg <= st_next;
            unit_reg <= unit_next;
            tmr_reg <= tmr_next;
            stop_prev_reg <= stop_prev_next;
            start_prev_reg <= start_prev_next;
            drive_reg <= drive_next;
            start_ev_reg <= start_ev_next;
            stop_ev_reg <= stop_ev_next;
            chrono_reg <= chrono_next;
        end
    end

    // open drain: pulls low while driving
    always_comb begin
        prover_control_output = 1'b0;
        prover_control_oe = drive_reg; // RULE9
        proving_indicator = (st_reg != PIPSP_IDLE); // RULE5
        start_event = start_ev_reg;
        stop_event = stop_ev_reg;
    end
endmodule

// [dv/pipsp_asserts.sv]
`timescale 1ns/1ps
// ----------------
// status checker
// ----------------
module pipsp_asserts
    import pipsp_pkg::*;
#(
    parameter int N_IN = 10,
    parameter int HOST_TIMEOUT = 16
)(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire logic [N_IN-1:0] input_enable,
    input wire logic [2*N_IN-1:0] input_led,
    input wire logic hotswap_ok,
    input wire logic init_done,
    input wire logic host_access,
    input wire logic backplane_fail,
    input wire logic [1:0] power_led,
    input wire logic [1:0] host_led,
    input wire logic fail_led_red,
    input wire logic proving_indicator,
    input wire logic prove_start,
    input wire logic detector_n_a,
    input wire logic prover_control_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    int idle_reg;
    int idle_next;
    // cycles since the last host access
    always_comb begin
        idle_next = idle_reg;
        if (srst || host_access) begin
            idle_next = 0;
        end else if (idle_reg < 255) begin
            idle_next = idle_reg + 1;
        end
    end
    always_ff @(posedge clk) begin
        idle_reg <= idle_next;
    end
    // a start request the block must take
    sequence s_start_taken;
        prove_start && !detector_n_a && !proving_indicator;
    endsequence
    sequence s_start_blocked;
        prove_start && detector_n_a && !proving_indicator;
    endsequence
    a_fail_led_on:
        assert property ($rose(backplane_fail) |-> ##[0:2] fail_led_red)
        else $error("fail led not lit");
    a_fail_led_off:
        assert property (!backplane_fail [*3] |-> !fail_led_red)
        else $error("fail led lit");
    a_power_green:
        assert property ((hotswap_ok && init_done) [*3]
            |-> power_led == PIPSP_LED_GREEN) else $error("power not green");
    a_power_red:
        assert property ((hotswap_ok && !init_done) [*3]
            |-> power_led == PIPSP_LED_RED) else $error("power not red");
    a_host_lost:
        assert property (idle_reg > HOST_TIMEOUT + 2
            |-> host_led == PIPSP_LED_RED) else $error("host led not red");
    a_host_seen:
        assert property (host_access |-> ##[1:3] host_led == PIPSP_LED_GREEN)
        else $error("host led not green");
    a_prove_taken:
        assert property (s_start_taken |=> prover_control_oe
            && proving_indicator) else $error("start not taken");
    a_start_refused:
        assert property (s_start_blocked |=> !proving_indicator)
        else $error("start not refused");
    a_oe_in_run:
        assert property (prover_control_oe |-> proving_indicator)
        else $error("output outside run");
    a_input_off:
        assert property (!input_enable[1] [*2]
            |-> input_led[3:2] == PIPSP_LED_OFF) else $error("led not off");
endmodule

bind pipsp_top pipsp_asserts #(
    .N_IN(N_IN),
    .HOST_TIMEOUT(HOST_TIMEOUT)
) pipsp_asserts_inst (
    .clk, .srst, .input_enable, .input_led, .hotswap_ok, .init_done,
    .host_access, .backplane_fail, .power_led, .host_led, .fail_led_red,
    .proving_indicator, .prove_start, .detector_n_a, .prover_control_oe
);

// [dv/pipsp_prover_model.sv]
`timescale 1ns/1ps
// ----------------
// compact prover model
// ----------------
module pipsp_prover_model #(
    parameter int RET_DLY = 12000
)(
    // clock
    input wire logic clk,
    // run command from the block
    input wire logic prover_control_oe,
    // detectors; input one and stop idle high on pull-ups, detector_n_a idles low
    output logic detector_n_a,
    output logic detector_input_one,
    output logic detector_stop
);
    // one low pulse on a detector line
    task automatic flash(input bit stop);
        if (stop) begin
            detector_stop <= 1'b0;
        end else begin
            detector_input_one <= 1'b0;
        end
        repeat (20) @(negedge clk);
        detector_stop <= 1'b1;
        detector_input_one <= 1'b1;
    endtask
    // piston pass, then return past both detectors
    initial begin
        detector_n_a = 1'b0;
        detector_input_one = 1'b1;
        detector_stop = 1'b1;
        forever begin
            @(posedge prover_control_oe);
            // input one passes while the run pulse is still on, stop after it has ended
            repeat (6000) @(negedge clk);
            flash(1'b0);
            repeat (6000) @(negedge clk);
            flash(1'b1);
            repeat (RET_DLY) @(negedge clk);
            flash(1'b1);
            repeat (500) @(negedge clk);
            flash(1'b0);
            repeat (200) @(negedge clk);
            detector_n_a <= 1'b1;
            repeat (300) @(negedge clk);
            detector_n_a <= 1'b0;
        end
    end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
// ----------------
// bench
// ----------------
module tb;
    import pipsp_pkg::*;
    localparam int N = 2;
    logic clk, srst, hotswap_ok, init_done, host_access, backplane_fail;
    logic [N-1:0] pulse_in, input_enable;
    logic [PER_W-1:0] freq_low_limit, freq_high_limit;
    logic [2*N-1:0] input_led;
    logic [1:0] power_led, host_led;
    logic fail_led_red, proving_indicator, prove_start;
    logic [15:0] prover_output_pulse_config;
    logic detector_n_a, detector_input_one, detector_stop;
    logic prover_control_output, prover_control_oe, start_event, stop_event;
    int errors, checks, per, wid, pc, n_start, n_stop, oe_cyc;
    pipsp_top #(.N_IN(N), .BLINK_COUNT(8), .HOST_TIMEOUT(16)) pipsp_top_inst (
        .clk, .srst, .pulse_in, .input_enable, .freq_low_limit,
        .freq_high_limit, .input_led, .hotswap_ok, .init_done, .host_access,
        .backplane_fail, .power_led, .host_led, .fail_led_red,
        .proving_indicator, .prove_start, .prover_output_pulse_config,
        .detector_n_a, .detector_input_one, .detector_stop,
        .prover_control_output, .prover_control_oe, .start_event, .stop_event
    );
    pipsp_prover_model pipsp_prover_model_inst (
        .clk, .prover_control_oe, .detector_n_a, .detector_input_one,
        .detector_stop
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulse source and tallies
    // b input a quarter period after a
    always @(negedge clk) begin
        pc = (pc + 1 >= per) ? 0 : pc + 1;
        pulse_in[0] <= pc < wid;
        pulse_in[1] <= (pc + per - per / 4) % per < wid;
    end
    // tallies taken where outputs have settled
    always @(negedge clk) begin
        n_start += start_event;
        n_stop += stop_event;
        oe_cyc += prover_control_oe;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // power, failure and host access indicators
    task automatic t_status();
        init_done = 1'b0;
        ticks(5);
        chk("power_led", power_led, PIPSP_LED_RED);
        init_done = 1'b1;
        ticks(5);
        chk("power_led", power_led, PIPSP_LED_GREEN);
        backplane_fail = 1'b1;
        ticks(3);
        chk("fail_led_red", fail_led_red, 1);
        backplane_fail = 1'b0;
        ticks(3);
        chk("fail_led_red", fail_led_red, 0);
        repeat (6) begin
            host_access = 1'b1;
            ticks(1);
            host_access = 1'b0;
            ticks(7);
        end
        chk("host_led", host_led, PIPSP_LED_GREEN);
        ticks(40);
        chk("host_led", host_led, PIPSP_LED_RED);
    endtask
    // one pulse train: 0 steady green, 1 blinking, 2 red
    task automatic classify(input int p, input int w, input int kind);
        int g, o, r, d;
        per = p;
        wid = w;
        g = 0;
        o = 0;
        r = 0;
        d = 0;
        ticks(3 * p);
        repeat (40) begin
            ticks(1);
            g += (input_led[1:0] === PIPSP_LED_GREEN);
            o += (input_led[1:0] === PIPSP_LED_OFF);
            r += (input_led[1:0] === PIPSP_LED_RED);
            d += (input_led[3:2] === PIPSP_LED_OFF);
        end
        chk("disabled_off", d, 40);
        chk("steady", g == 40, kind == 0);
        chk("blink", g > 0 && o > 0 && r == 0, kind == 1);
        chk("red", r == 40, kind == 2);
    endtask
    // limits are periods of 2000 and 500 cycles
    task automatic t_inputs();
        classify(1000, 500, 0);
        classify(3000, 1500, 1);
        classify(450, 225, 1);
        classify(1000, 50, 2);
        classify(300, 150, 2);
    endtask
    // one proving run, then a start while the piston is home
    task automatic t_prove();
        int i;
        prove_start = 1'b1;
        ticks(1);
        prove_start = 1'b0;
        ticks(1);
        chk("oe", prover_control_oe, 1);
        chk("proving", proving_indicator, 1);
        for (i = 0; i < 40000 && detector_n_a !== 1'b1; i++) begin
            ticks(1);
        end
        if (detector_n_a !== 1'b1) begin
            errors++; // run never came home
        end else begin
            ticks(5);
            chk("oe_cycles", oe_cyc, PULSE_UNIT_CYC);
            chk("start_events", n_start, 1);
            chk("stop_events", n_stop, 1);
            chk("proving", proving_indicator, 0);
            prove_start = 1'b1;
            ticks(1);
            prove_start = 1'b0;
            ticks(3);
            chk("refused", proving_indicator | prover_control_oe, 0);
        end
    endtask
    initial begin
        srst = 1'b1;
        input_enable = 2'h1;
        freq_low_limit = 22'h0007D0;
        freq_high_limit = 22'h0001F4;
        hotswap_ok = 1'b1;
        init_done = 1'b1;
        host_access = 1'b0;
        backplane_fail = 1'b0;
        prove_start = 1'b0;
        prover_output_pulse_config = 16'h0001;
        per = 1000;
        wid = 500;
        ticks(16);
        srst = 1'b0;
        ticks(2);
        t_status();
        t_inputs();
        t_prove();
        print_verdict();
    end
endmodule
